// ===== inc/pbt_pkg.sv
// Functional notes
// - latch pulse half or one-and-half clocks
// - unlatched code cycle one to four clocks
// - latched code cycle two to five clocks
// - latched code strobe is length minus latch minus half
// - burst fetch keeps program strobe low across cycles
// - unlatched data read one to four clocks
// - latched data read two to five clocks
// - latched read strobe is length minus latch minus half
// - split 16-bit read keeps read strobe low
// - write strobe one or two clocks
// - write hold zero or one clock
// - write cycle two to five clocks, lead derived
// - latched write data starts after latch gap
// - write data leads strobe by computed gap
// - wait stretches reads only from second clock
// - write hold extension is the default
`default_nettype none

package pbt_pkg;

	// ************************************************************
	// register map and fields
	// ************************************************************
	localparam logic [7:0] OFS_BT_LOW  = 8'h00;
	localparam logic [7:0] OFS_BT_HIGH = 8'h04;
	localparam logic [7:0] OFS_STATUS  = 8'h08;

	localparam int BTL_CODE_LSB  = 0;
	localparam int BTL_LCODE_LSB = 2;
	localparam int BTL_LATCH_PULSE_WIDE_BIT_BIT  = 4;
	localparam int BTL_WSW_BIT   = 5;
	localparam int BTL_WHX_BIT   = 6;
	localparam int BTH_DRD_LSB   = 0;
	localparam int BTH_LDRD_LSB  = 2;
	localparam int BTH_DWR_LSB   = 4;
	localparam int BTH_LDWR_LSB  = 6;
	localparam int STS_BUSY_BIT  = 0;
	localparam int STS_KIND_LSB  = 1;

	// slowest timing after reset; hold extension on
	localparam logic [7:0] BTL_RST = 8'h4F;
	localparam logic [7:0] BTH_RST = 8'hFF;

	// ************************************************************
	// timing in half clocks, clock period in ns
	// ************************************************************
	localparam int         CLK_PERIOD_NS = 5;
	localparam logic [5:0] HALF_PER_CLK  = 6'h02;
	localparam logic [5:0] ALE_NARROW    = 6'h01;
	localparam logic [5:0] ALE_WIDE      = 6'h03;
	localparam logic [5:0] ALE_GAP       = 6'h01;
	localparam logic [5:0] WR_NARROW     = 6'h02;
	localparam logic [5:0] WR_WIDE       = 6'h04;
	localparam logic [5:0] HOLD_EXT      = 6'h02;
	localparam logic [5:0] UNL_BASE      = 6'h01;
	localparam logic [5:0] LAT_BASE      = 6'h02;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {
		K_CODE  = 2'b00,
		K_READ  = 2'b01,
		K_WRITE = 2'b10
	} pbt_kind_t;

	typedef struct packed {
		logic [5:0] tlen;
		logic [5:0] ale_e;
		logic [5:0] str_s;
		logic [5:0] str_e;
		logic [5:0] dat_s;
	} pbt_tim_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} pbt_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} pbt_wb_rsp_t;

	typedef struct packed {
		pbt_kind_t   kind;
		logic        lat;
		logic        pair;
		logic [19:0] addr;
		logic [15:0] wdata;
		logic [1:0]  be;
	} pbt_req_t;

	// two-bit strobes: bit 0 first half of the clock, bit 1 second half
	typedef struct packed {
		logic [1:0]  ale;
		logic [1:0]  program_fetch_strobe_n;
		logic [1:0]  rd_n;
		logic [1:0]  wrl_n;
		logic [1:0]  wrh_n;
		logic [1:0]  dat_oe_n;
		logic [19:0] addr;
		logic [15:0] dout;
	} pbt_pins_t;

endpackage : pbt_pkg

`default_nettype wire

// ===== src/pbt_bus_seq.sv
`default_nettype none

module pbt_bus_seq
	import pbt_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// register bus
	input  wire pbt_wb_req_t wb_i,
	output var  pbt_wb_rsp_t wb_o,
	// bus cycle requests
	input  wire logic        req_valid_i,
	input  wire pbt_req_t    req_i,
	output logic             req_ready_o,
	// read answers
	output logic             rvalid_o,
	output logic [15:0]      rdata_o,
	// external bus pins
	input  wire logic        wait_i,
	input  wire logic [15:0] data_i,
	output var  pbt_pins_t   pins_o
);

	// ************************************************************
	// types and functions
	// ************************************************************
	typedef struct packed {
		logic        busy;
		logic        fresh;
		logic        lat;
		logic        pair_pend;
		logic        hi_byte;
		logic        cap_v;
		logic        rvalid;
		pbt_kind_t   kind;
		logic [5:0]  pos;
		pbt_tim_t    tim;
		logic [19:0] addr;
		logic [15:0] wdata;
		logic [1:0]  be;
		logic        w_s1;
		logic        w_s2;
		logic [15:0] cap;
		logic [15:0] rdata;
		pbt_pins_t   pins;
	} pbt_st_t;

	pbt_st_t     q, d;
	logic [7:0]  btl;
	logic [7:0]  bth;
	logic        stall;
	logic        last;
	logic        end_str;
	logic        ld;

	// cycle length in half clocks from a two-bit field
	function automatic logic [5:0] len2(input logic [1:0] f, input logic [5:0] base);
		len2 = ({4'h0, f} + base) << 1;
	endfunction : len2

	// half position inside [s, e)
	function automatic logic inwin(input logic [5:0] p, input logic [5:0] s,
		input logic [5:0] e);
		inwin = (p >= s) && (p < e);
	endfunction : inwin

	// both halves of one clock starting at half p
	function automatic logic [1:0] win2(input logic [5:0] p, input logic [5:0] s,
		input logic [5:0] e);
		win2 = {inwin(p + 6'h01, s, e), inwin(p, s, e)};
	endfunction : win2

	// count of low halves in a two-bit strobe
	function automatic logic [5:0] lows(input logic [1:0] v);
		lows = {5'h00, !v[0]} + {5'h00, !v[1]};
	endfunction : lows

	// edge positions of one bus cycle, all in half clocks
	function automatic pbt_tim_t calc(input pbt_kind_t k, input logic lat,
		input logic [7:0] lo, input logic [7:0] hi);
		pbt_tim_t   t;
		logic [5:0] a;
		logic [5:0] w;
		logic [5:0] h;
		t = '0;
		a = lo[BTL_LATCH_PULSE_WIDE_BIT_BIT] ? ALE_WIDE : ALE_NARROW;
		w = lo[BTL_WSW_BIT] ? WR_WIDE : WR_NARROW;
		h = lo[BTL_WHX_BIT] ? HOLD_EXT : 6'h00;
		unique case (k)
			K_CODE:
				t.tlen = lat ? len2(lo[BTL_LCODE_LSB +: 2], LAT_BASE)
					: len2(lo[BTL_CODE_LSB +: 2], UNL_BASE);
			K_READ:
				t.tlen = lat ? len2(hi[BTH_LDRD_LSB +: 2], LAT_BASE)
					: len2(hi[BTH_DRD_LSB +: 2], UNL_BASE);
			K_WRITE:
				t.tlen = lat ? len2(hi[BTH_LDWR_LSB +: 2], LAT_BASE)
					: len2(hi[BTH_DWR_LSB +: 2], LAT_BASE);
			default:
				t.tlen = HALF_PER_CLK;
		endcase
		t.ale_e = lat ? a : 6'h00;
		if (k == K_WRITE)
		begin
			// strobe sits before the hold; lead is what remains, never negative
			t.str_e = t.tlen - h;
			t.str_s = (t.str_e > w) ? t.str_e - w : 6'h00;
			t.dat_s = lat ? a + ALE_GAP : 6'h00;
		end
		else
		begin
			t.str_e = t.tlen;
			t.str_s = lat ? a + ALE_GAP : 6'h00;
			t.dat_s = t.tlen;
		end
		return t;
	endfunction : calc

	// ************************************************************
	// register file
	// ************************************************************
	pbt_regs u_regs (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.wb_i   (wb_i),
		.wb_o   (wb_o),
		.busy_i (q.busy),
		.kind_i (q.kind),
		.btl_o  (btl),
		.bth_o  (bth)
	);

	// ready is combinational so back-to-back fetches chain without a gap
	assign req_ready_o = !q.busy || (last && !q.pair_pend);

	// ************************************************************
	// sequencer next state
	// ************************************************************
	always_comb
	begin
		d = q;
		d.w_s1 = wait_i;
		d.w_s2 = q.w_s1;
		d.fresh = 1'b0;
		d.cap_v = 1'b0;
		d.rvalid = 1'b0;
		ld = 1'b0;
		if (q.cap_v)
		begin
			d.rdata = q.cap;
			d.rvalid = 1'b1;
		end
		// only the last strobe clock may stretch; reads need a second clock first
		end_str = q.busy && (q.pos + HALF_PER_CLK == q.tim.str_e);
		stall = end_str && q.w_s2
			&& (q.kind != K_READ || q.pos >= q.tim.str_s + HALF_PER_CLK);
		last = q.busy && (q.pos + HALF_PER_CLK >= q.tim.tlen) && !stall;
		// capture stage reads the pins once, a copy stage feeds the port
		if (end_str && !stall && q.kind != K_WRITE)
		begin
			if (q.hi_byte)
				d.cap[15:8] = data_i[7:0];
			else if (q.pair_pend)
				d.cap[7:0] = data_i[7:0];
			else
				d.cap = data_i;
			d.cap_v = !q.pair_pend;
		end
		// ready is rebuilt here so this process never reads its own result back
		if (req_valid_i && (!q.busy || (last && !q.pair_pend)))
		begin
			ld = 1'b1;
			d.busy = 1'b1;
			d.kind = req_i.kind;
			d.pair_pend = req_i.pair && (req_i.kind == K_READ);
			d.lat = req_i.lat || d.pair_pend;
			d.hi_byte = 1'b0;
			d.tim = calc(req_i.kind, d.lat, btl, bth);
			d.pos = 6'h00;
			d.addr = req_i.addr;
			d.wdata = req_i.wdata;
			d.be = req_i.be;
		end
		else if (last && q.pair_pend)
		begin
			// second byte: no latch pulse, A0 rises, strobe runs on
			ld = 1'b1;
			d.pair_pend = 1'b0;
			d.hi_byte = 1'b1;
			d.lat = 1'b0;
			d.tim = calc(K_READ, 1'b0, btl, bth);
			d.pos = 6'h00;
			d.addr = q.addr | 20'h0_0001;
		end
		else if (last)
			d.busy = 1'b0;
		else if (q.busy && !stall)
			d.pos = q.pos + HALF_PER_CLK;
		d.fresh = ld;
		// pin levels for the clock that d describes
		d.pins.ale = 2'b00;
		d.pins.program_fetch_strobe_n = 2'b11;
		d.pins.rd_n = 2'b11;
		d.pins.wrl_n = 2'b11;
		d.pins.wrh_n = 2'b11;
		d.pins.dat_oe_n = 2'b11;
		d.pins.addr = d.addr;
		d.pins.dout = d.wdata;
		if (d.busy)
		begin
			d.pins.ale = win2(d.pos, 6'h00, d.tim.ale_e);
			unique case (d.kind)
				K_CODE:
					d.pins.program_fetch_strobe_n = ~win2(d.pos, d.tim.str_s, d.tim.str_e);
				K_READ:
					d.pins.rd_n = ~win2(d.pos, d.tim.str_s, d.tim.str_e);
				K_WRITE:
				begin
					d.pins.wrl_n = ~(win2(d.pos, d.tim.str_s, d.tim.str_e)
						& {2{d.be[0]}});
					d.pins.wrh_n = ~(win2(d.pos, d.tim.str_s, d.tim.str_e)
						& {2{d.be[1]}});
					d.pins.dat_oe_n = ~win2(d.pos, d.tim.dat_s, d.tim.tlen);
				end
				default:
					d.pins.program_fetch_strobe_n = 2'b11;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q <= '0;
			q.pins.ale <= 2'b00;
			q.pins.program_fetch_strobe_n <= 2'b11;
			q.pins.rd_n <= 2'b11;
			q.pins.wrl_n <= 2'b11;
			q.pins.wrh_n <= 2'b11;
			q.pins.dat_oe_n <= 2'b11;
		end
		else
			q <= d;
	end

	assign pins_o   = q.pins;
	assign rvalid_o = q.rvalid;
	assign rdata_o  = q.rdata;

	// ************************************************************
	// checks
	// ************************************************************
	logic [3:0] a_clk;
	logic       a_st;
	logic [5:0] a_str;
	logic [5:0] a_oe;
	logic [7:0] a_lo;
	logic [7:0] a_hi;
	logic [3:0] c_clk;
	logic       c_st;
	logic [5:0] c_str;
	logic [5:0] c_oe;
	logic [1:0] strobe_now;

	// running totals of the current cycle, this clock included
	always_comb
	begin
		unique case (q.kind)
			K_CODE:  strobe_now = q.pins.program_fetch_strobe_n;
			K_READ:  strobe_now = q.pins.rd_n;
			K_WRITE: strobe_now = q.pins.wrl_n & q.pins.wrh_n;
			default: strobe_now = 2'b11;
		endcase
		c_clk = (q.fresh ? 4'h0 : a_clk) + 4'h1;
		c_st  = (q.fresh ? 1'b0 : a_st) || stall;
		c_str = (q.fresh ? 6'h00 : a_str) + lows(strobe_now);
		c_oe  = (q.fresh ? 6'h00 : a_oe) + lows(q.pins.dat_oe_n);
	end

	// helper counters for the checks
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			a_clk <= 4'h0;
			a_st <= 1'b0;
			a_str <= 6'h00;
			a_oe <= 6'h00;
			a_lo <= 8'h00;
			a_hi <= 8'h00;
		end
		else
		begin
			a_clk <= c_clk;
			a_st <= c_st;
			a_str <= c_str;
			a_oe <= c_oe;
			if (ld)
			begin
				a_lo <= btl;
				a_hi <= bth;
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_ale_wide;
		q.pins.ale == 2'b11 ##1 q.pins.ale == 2'b01 ##1 q.pins.ale == 2'b00;
	endsequence
	sequence s_ale_narrow;
		q.pins.ale == 2'b01 ##1 q.pins.ale == 2'b00;
	endsequence

	AST_ALE_WIDE: assert property (q.fresh && q.lat && a_lo[BTL_LATCH_PULSE_WIDE_BIT_BIT]
		&& q.tim.tlen > 6'h04 |-> s_ale_wide)
		else $error("wide latch pulse not one and a half clocks");
	AST_ALE_NARROW: assert property (q.fresh && q.lat && !a_lo[BTL_LATCH_PULSE_WIDE_BIT_BIT]
		|-> s_ale_narrow)
		else $error("narrow latch pulse not half a clock");
	AST_CODE_UNL: assert property (last && !c_st && q.kind == K_CODE && !q.lat
		|-> c_clk == {2'b00, a_lo[BTL_CODE_LSB +: 2]} + 4'h1 && c_str == {c_clk, 1'b0})
		else $error("unlatched code cycle length wrong");
	AST_CODE_LAT: assert property (last && !c_st && q.kind == K_CODE && q.lat
		|-> c_clk == {2'b00, a_lo[BTL_LCODE_LSB +: 2]} + 4'h2
		&& c_str == {c_clk, 1'b0} - q.tim.ale_e - ALE_GAP)
		else $error("latched code cycle or strobe wrong");
	AST_RD_UNL: assert property (last && !c_st && q.kind == K_READ && !q.lat
		|-> c_clk == {2'b00, a_hi[BTH_DRD_LSB +: 2]} + 4'h1 && c_str == {c_clk, 1'b0})
		else $error("unlatched read cycle length wrong");
	AST_RD_LAT: assert property (last && !c_st && q.kind == K_READ && q.lat
		|-> c_clk == {2'b00, a_hi[BTH_LDRD_LSB +: 2]} + 4'h2
		&& c_str == {c_clk, 1'b0} - q.tim.ale_e - ALE_GAP)
		else $error("latched read cycle or strobe wrong");
	AST_WR_LEN: assert property (last && !c_st && q.kind == K_WRITE
		|-> c_clk == {2'b00, (q.lat ? a_hi[BTH_LDWR_LSB +: 2] : a_hi[BTH_DWR_LSB +: 2])}
		+ 4'h2 && c_str == (a_lo[BTL_WSW_BIT] ? WR_WIDE : WR_NARROW))
		else $error("write cycle or strobe width wrong");
	AST_WR_DATA: assert property (last && !c_st && q.kind == K_WRITE
		|-> c_oe == {c_clk, 1'b0} - (q.lat ? q.tim.ale_e + ALE_GAP : 6'h00))
		else $error("write data drive window wrong");
	AST_WR_HOLD: assert property (last && q.kind == K_WRITE && a_lo[BTL_WHX_BIT]
		|-> (q.pins.wrl_n & q.pins.wrh_n) == 2'b11 && q.pins.dat_oe_n == 2'b00)
		else $error("write hold clock missing");
	AST_WAIT_HOLD: assert property (end_str && q.w_s2 && q.kind != K_READ
		|=> $stable(q.pos) && strobe_now == 2'b00)
		else $error("wait did not stretch strobe");
	AST_WAIT_SHORT_RD: assert property (q.busy && q.kind == K_READ && end_str
		&& q.tim.str_e == q.tim.str_s + HALF_PER_CLK |-> !stall)
		else $error("single clock read was stretched");
	AST_BURST: assert property (last && q.kind == K_CODE && req_valid_i
		&& req_i.kind == K_CODE && !req_i.lat |-> q.pins.program_fetch_strobe_n == 2'b00
		##1 q.pins.program_fetch_strobe_n == 2'b00)
		else $error("program strobe toggled in burst");
	AST_PAIR: assert property (last && q.pair_pend
		|=> q.pins.rd_n == 2'b00 && q.pins.ale == 2'b00 && q.pins.addr[0])
		else $error("split read second byte wrong");
	AST_HOLD_RST: assert property (@(posedge clk_i) disable iff (1'b0)
		rst_i ##1 !rst_i |-> btl[BTL_WHX_BIT])
		else $error("hold extension not set after reset");

endmodule : pbt_bus_seq

`default_nettype wire

// ===== src/pbt_regs.sv
`default_nettype none

module pbt_regs
	import pbt_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire pbt_wb_req_t wb_i,
	output var  pbt_wb_rsp_t wb_o,
	// sequencer side
	input  wire logic        busy_i,
	input  wire pbt_kind_t   kind_i,
	output logic [7:0]       btl_o,
	output logic [7:0]       bth_o
);

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
		logic [7:0]  btl;
		logic [7:0]  bth;
	} pbt_rst_t;

	pbt_rst_t q, d;

	// ************************************************************
	// decode: one wait state, unmapped reads zero
	// ************************************************************
	always_comb
	begin
		d = q;
		d.ack = wb_i.cyc && wb_i.stb && !q.ack; // ack drops the cycle after
		d.dat = 32'h0000_0000;
		if (d.ack)
		begin
			unique case (wb_i.adr)
				OFS_BT_LOW:
				begin
					if (wb_i.we && wb_i.sel[0])
						d.btl = wb_i.dat[7:0];
					d.dat = {24'h00_0000, q.btl};
				end
				OFS_BT_HIGH:
				begin
					if (wb_i.we && wb_i.sel[0])
						d.bth = wb_i.dat[7:0];
					d.dat = {24'h00_0000, q.bth};
				end
				OFS_STATUS:
					d.dat = {29'h0000_0000, kind_i, busy_i};
				default:
					d.dat = 32'h0000_0000; // writes ignored
			endcase
		end
	end

	// state register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q.ack <= 1'b0;
			q.dat <= 32'h0000_0000;
			q.btl <= BTL_RST;
			q.bth <= BTH_RST;
		end
		else
			q <= d;
	end

	assign wb_o.ack = q.ack;
	assign wb_o.dat = q.dat;
	assign btl_o    = q.btl;
	assign bth_o    = q.bth;

endmodule : pbt_regs

`default_nettype wire

// ===== tb/pbt_mem_model.sv
`default_nettype none

// ************************************************************
// external memory with optional wait stretching
// ************************************************************
module pbt_mem_model
	import pbt_pkg::*;
#(
	parameter int WAIT_CLKS = 4
)
(
	// clock and reset
	input  wire logic      clk_i,
	input  wire logic      rst_i,
	// bench control
	input  wire logic      stretch_i,
	// bus pins
	input  wire pbt_pins_t pins_i,
	output logic           wait_o,
	output logic [15:0]    data_o
);
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct packed {
		logic [3:0]  low_adr;
		logic [3:0]  cnt;
		logic [15:0] drv;
	} pbt_mdl_t;

	pbt_mdl_t st_q;
	pbt_mdl_t st_d;
	logic     strb_low;
	logic     new_cyc;

	// burst and split cycles carry no fresh strobe edge, so watch the low address bits
	assign strb_low = (pins_i.rd_n != 2'h3) || (pins_i.program_fetch_strobe_n != 2'h3);
	assign new_cyc  = (pins_i.ale != 2'h0) || (pins_i.addr[3:0] != st_q.low_adr);
	// a released bus shows the inverse of the previous clock's value, so it toggles every clock
	assign data_o   = strb_low ? {pins_i.addr[7:0] ^ 8'h5A, pins_i.addr[7:0]} : ~st_q.drv;
	// wait stays bounded so a stretched strobe always ends
	assign wait_o   = stretch_i && strb_low && (st_q.cnt < 4'(WAIT_CLKS));

	// next state: strobe clocks counted since the last cycle start
	always_comb
	begin
		st_d = st_q;
		st_d.low_adr = pins_i.addr[3:0];
		st_d.drv = data_o;
		if (new_cyc)
			st_d.cnt = 4'h0;
		else if (strb_low && st_q.cnt != 4'hF)
			st_d.cnt = st_q.cnt + 4'h1;
	end

	// state register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end
endmodule : pbt_mem_model

`default_nettype wire

// ===== tb/tb_top.sv
`default_nettype none

module tb_top
	import pbt_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct {
		pbt_kind_t k;
		int        lat, f, latch_pulse_wide_bit, wsw, whx, n, str, ale, gap, lead, hold;
	} pbt_row_t;

	// ************************************************************
	// signals and instances
	// ************************************************************
	logic        clk_i;
	logic        rst_i;
	pbt_wb_req_t wb_i;
	pbt_wb_rsp_t wb_o;
	logic        req_valid_i;
	pbt_req_t    req_i;
	logic        req_ready_o;
	logic        rvalid_o;
	logic [15:0] rdata_o;
	logic        wait_i;
	logic [15:0] data_i;
	pbt_pins_t   pins_o;
	logic        stretch;
	int          err_count, check_count, h, ale_c, ale_last, str_c, runs;
	int          s_first, s_last, oe_start, oe_last, bad_d;
	logic        prev_s, prev_oe;
	pbt_kind_t   cur_k;
	logic [15:0] exp_wd;
	logic [31:0] wd;
	logic [15:0] d;
	int          n;
	pbt_row_t    rows [14] = '{
		'{K_CODE, 0, 0, 0, 0, 1, 1, 2, 0, -1, 0, 0}, '{K_CODE, 0, 1, 0, 0, 1, 2, 4, 0, -1, 0, 0},
		'{K_CODE, 0, 2, 0, 0, 1, 3, 6, 0, -1, 0, 0}, '{K_CODE, 0, 3, 0, 0, 1, 4, 8, 0, -1, 0, 0},
		'{K_CODE, 1, 2, 1, 0, 1, 4, 4, 3, -1, 0, 0}, '{K_CODE, 1, 0, 0, 0, 1, 2, 2, 1, -1, 0, 0},
		'{K_READ, 0, 0, 0, 0, 1, 1, 2, 0, -1, 0, 0}, '{K_READ, 0, 3, 0, 0, 1, 4, 8, 0, -1, 0, 0},
		'{K_READ, 1, 3, 1, 0, 1, 5, 6, 3, -1, 0, 0}, '{K_READ, 1, 0, 0, 0, 1, 2, 2, 1, -1, 0, 0},
		'{K_WRITE, 1, 3, 0, 0, 1, 5, 2, 1, 5, 4, 2}, '{K_WRITE, 0, 0, 0, 0, 0, 2, 2, 0, -1, 2, 0},
		'{K_WRITE, 0, 3, 0, 1, 1, 5, 4, 0, -1, 4, 2}, '{K_WRITE, 1, 2, 1, 0, 1, 4, 2, 3, 1, 0, 2}};

	pbt_bus_seq u_pbt_bus_seq (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
		.req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
		.rvalid_o(rvalid_o), .rdata_o(rdata_o), .wait_i(wait_i), .data_i(data_i),
		.pins_o(pins_o));
	pbt_mem_model #(.WAIT_CLKS(4)) u_pbt_mem_model (.clk_i(clk_i), .rst_i(rst_i),
		.stretch_i(stretch), .pins_i(pins_o), .wait_o(wait_i), .data_o(data_i));

	// 200 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// pin monitor: each clock gives two half-clock samples
	always @(posedge clk_i)
	begin
		logic s;
		#1;
		for (int b = 0; b < 2; b++)
		begin
			s = cur_k == K_CODE ? pins_o.program_fetch_strobe_n[b] : cur_k == K_READ ? pins_o.rd_n[b] : pins_o.wrl_n[b];
			if (pins_o.ale[b] === 1'b1)
			begin
				ale_c++;
				ale_last = h;
			end
			if (s === 1'b0)
			begin
				runs += (prev_s !== 1'b0);
				s_first = (s_first < 0) ? h : s_first;
				s_last = h;
				str_c++;
				bad_d += (cur_k == K_WRITE && pins_o.dout !== exp_wd);
			end
			if (pins_o.dat_oe_n[b] === 1'b0)
			begin
				oe_start = (prev_oe !== 1'b0) ? h : oe_start;
				oe_last = h;
			end
			prev_s = s;
			prev_oe = pins_o.dat_oe_n[b];
			h++;
		end
	end

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic chk_i(input string m, input int g, input int e);
		check_count++;
		if (g != e)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t %s got %0d exp %0d", $time, m, g, e);
		end
	endtask : chk_i

	task automatic chk_v(input string m, input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk_v

	task automatic mon_clr();
		{h, ale_c, str_c, runs, bad_d} = '0;
		{ale_last, s_first, s_last, oe_start, oe_last} = {5{-32'sd1}};
		prev_s = 1'b1;
		prev_oe = 1'b1;
	endtask : mon_clr

	// classic single cycle; request held until ack is seen
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] v,
		output logic [31:0] rd);
		int k;
		wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: {24'h0, v}};
		k = 0;
		do
		begin
			@(posedge clk_i);
			#1;
			k++;
		end
		while (wb_o.ack !== 1'b1 && k < 20);
		if (wb_o.ack !== 1'b1)
			err_count++;
		rd = wb_o.dat;
		@(posedge clk_i);
		wb_i <= '0;
		@(posedge clk_i);
	endtask : wb_xfer

	// counts clocks until ready, returns at the edge that takes a waiting request
	task automatic wait_rdy(output int c);
		logic rdy;
		c = 0;
		do
		begin
			#1;
			c++;
			rdy = req_ready_o;
			@(posedge clk_i);
		end
		while (rdy !== 1'b1 && c < 60);
		if (rdy !== 1'b1)
			err_count++;
	endtask : wait_rdy

	// one request, monitor restarted at its take edge, read answer collected
	task automatic do_req(input pbt_req_t r, output int c, output logic [15:0] rd);
		exp_wd = r.wdata;
		cur_k = r.kind;
		req_i <= r;
		req_valid_i <= 1'b1;
		wait_rdy(c);
		req_valid_i <= 1'b0;
		mon_clr();
		wait_rdy(c);
		rd = 'x;
		repeat (20)
		begin
			#1;
			rd = (rvalid_o === 1'b1) ? rdata_o : rd;
			@(posedge clk_i);
		end
	endtask : do_req

	task automatic run_row(input pbt_row_t w, input int i);
		pbt_req_t r;
		wb_xfer(1'b1, OFS_BT_LOW, {1'b0, 1'(w.whx), 1'(w.wsw), 1'(w.latch_pulse_wide_bit), 2'(w.f), 2'(w.f)}, wd);
		wb_xfer(1'b1, OFS_BT_HIGH, {4{2'(w.f)}}, wd);
		r = '{kind: w.k, lat: 1'(w.lat), pair: 1'b0, addr: 20'h12340 + 20'(i),
			wdata: 16'hB7E1, be: 2'h1};
		do_req(r, n, d);
		chk_v("bus address", pins_o.addr[15:0], r.addr[15:0]);
		chk_i("cycle length", n, w.n);
		chk_i("strobe halves", str_c, w.str);
		chk_i("latch halves", ale_c, w.ale);
		chk_i("strobe runs", runs, 1);
		if (w.k != K_WRITE)
			chk_v("read data", d, {r.addr[7:0] ^ 8'h5A, r.addr[7:0]});
		else
		begin
			if (w.gap >= 0)
				chk_i("latch to strobe", s_first - ale_last - 1, w.gap);
			chk_i("data lead", s_first - oe_start, w.lead);
			chk_i("write hold", oe_last - s_last, w.hold);
			chk_i("write data", bad_d, 0);
		end
		$display("test row %0d done", i);
	endtask : run_row

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	// watchdog against a hung handshake
	initial
	begin
		#100000;
		err_count++;
		print_verdict();
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		{rst_i, wb_i, req_valid_i, req_i, stretch, err_count, check_count} = '0;
		rst_i = 1'b1;
		cur_k = K_CODE;
		mon_clr();
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rows[i])
			run_row(rows[i], i);
		// burst: second fetch queued while the first runs
		wb_xfer(1'b1, OFS_BT_LOW, 8'h45, wd);
		cur_k = K_CODE;
		req_i <= '{kind: K_CODE, lat: 1'b0, pair: 1'b0, addr: 20'h00200, wdata: 16'h0, be: 2'h0};
		req_valid_i <= 1'b1;
		wait_rdy(n);
		req_i <= '{kind: K_CODE, lat: 1'b0, pair: 1'b0, addr: 20'h00202, wdata: 16'h0, be: 2'h0};
		mon_clr();
		wait_rdy(n);
		chk_i("burst first length", n, 2);
		req_valid_i <= 1'b0;
		wait_rdy(n);
		chk_i("burst second length", n, 2);
		repeat (4) @(posedge clk_i);
		chk_i("burst strobe runs", runs, 1);
		chk_i("burst strobe halves", str_c, 8);
		$display("test burst done");
		// 16-bit read over the byte bus
		wb_xfer(1'b1, OFS_BT_HIGH, 8'h55, wd);
		do_req('{kind: K_READ, lat: 1'b0, pair: 1'b1, addr: 20'h00A42, wdata: 16'h0, be: 2'h0}, n, d);
		chk_v("pair data", d, 16'h4342);
		chk_i("pair strobe runs", runs, 1);
		chk_i("pair latch halves", ale_c, 1);
		$display("test pair done");
		// wait on reads: stretches a three clock strobe, never a one clock strobe
		stretch <= 1'b1;
		wb_xfer(1'b1, OFS_BT_HIGH, 8'hAA, wd);
		do_req('{kind: K_READ, lat: 1'b0, pair: 1'b0, addr: 20'h00315, wdata: 16'h0, be: 2'h0}, n, d);
		chk_i("stretched", int'(str_c > 6), 1);
		chk_v("stretched data", d, 16'h4F15);
		wb_xfer(1'b1, OFS_BT_HIGH, 8'h00, wd);
		do_req('{kind: K_READ, lat: 1'b0, pair: 1'b0, addr: 20'h00326, wdata: 16'h0, be: 2'h0}, n, d);
		chk_i("single clock read", str_c, 2);
		// four clock fetch: wait seen in its second clock stretches the last one
		wb_xfer(1'b1, OFS_BT_LOW, 8'h4F, wd);
		do_req('{kind: K_CODE, lat: 1'b0, pair: 1'b0, addr: 20'h00337, wdata: 16'h0, be: 2'h0}, n, d);
		chk_i("stretched fetch", int'(str_c > 8), 1);
		chk_v("stretched fetch data", d, 16'h6D37);
		stretch <= 1'b0;
		$display("test wait done");
		// second reset in mid-run
		rst_i <= 1'b1;
		repeat (16) @(posedge clk_i);
		#1;
		chk_i("idle pins", int'(pins_o.ale === 2'h0 && pins_o.rd_n === 2'h3
			&& pins_o.program_fetch_strobe_n === 2'h3 && pins_o.dat_oe_n === 2'h3), 1);
		@(posedge clk_i);
		rst_i <= 1'b0;
		wb_xfer(1'b0, OFS_BT_LOW, 8'h00, wd);
		chk_v("low reset", wd[15:0], 16'h004F);
		wb_xfer(1'b0, OFS_BT_HIGH, 8'h00, wd);
		chk_v("high reset", wd[15:0], 16'h00FF);
		wb_xfer(1'b0, 8'h0C, 8'h00, wd);
		chk_v("unmapped", wd[15:0], 16'h0000);
		wb_xfer(1'b0, OFS_STATUS, 8'h00, wd);
		chk_v("status reset", wd[15:0], 16'h0000);
		$display("test reset done");
		print_verdict();
	end
endmodule : tb_top

`default_nettype wire
